// file: verilog/tlb_regs_pkg.sv
// Package of shared constants for the translation buffer control register set.
// Assumes a 64-entry software-refilled buffer and register numbers as decoded by the pipeline.
package tlb_regs_pkg;
	// ==========================================================
	// Register selectors (register number, select)
	// ==========================================================
	localparam logic [7:0] SEL_SLOT = 8'h00;
	localparam logic [7:0] SEL_REPL = 8'h08;
	localparam logic [7:0] SEL_EVEN = 8'h10;
	localparam logic [7:0] SEL_ODD = 8'h18;
	localparam logic [7:0] SEL_PTP = 8'h20;
	localparam logic [7:0] SEL_PSIZE = 8'h28;
	localparam logic [7:0] SEL_GRAIN = 8'h29;
	localparam logic [7:0] SEL_PINNED = 8'h30;
	localparam logic [7:0] SEL_HWGATE = 8'h38;
	localparam logic [7:0] SEL_FAULT = 8'h40;
	localparam logic [7:0] SEL_TALLY = 8'h48;
	localparam logic [7:0] SEL_ALARM = 8'h58;
	// ==========================================================
	// Field layout
	// ==========================================================
	localparam int IDX_W = 6;
	localparam logic [5:0] TOP_ENTRY = 6'h3f;
	localparam int PROBE_FAIL_BIT = 31;
	localparam int WIDE_PHYS_BIT = 29;
	localparam int HWGATE_W = 4;
	localparam int LO_USED_W = 42;
	localparam int VPAIR_LSB = 13;
	localparam int VPAIR_MSB = 31;
	localparam int VPAIR_W = 19;
	localparam int VPAIR_POS = 4;
	localparam int BASE_LSB = 23;
	localparam int MASK_LSB = 13;
	localparam int MASK_MSB = 24;
	localparam int PIPE_IRQ_BIT = 7;
	localparam logic [63:0] ZERO64 = 64'h0;
	localparam logic [31:0] ZERO32 = 32'h0;
	localparam logic [5:0] ZERO6 = 6'h0;
	localparam logic [5:0] ONE6 = 6'h01;
	localparam logic [31:0] ONE32 = 32'h00000001;
endpackage

// file: verilog/repl_pointer.sv
// Replacement pointer: walks down between the pinned boundary and the top entry.
// Assumes one retire pulse per executed instruction from the pipeline.
`timescale 1ns/10ps
module repl_pointer (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_retire,
	input wire logic i_reload,
	input wire logic [5:0] i_lower,
	output logic [5:0] o_pointer
);
	// ==========================================================
	// Pointer register
	// ==========================================================
	// Reset and reload both put the pointer at the top entry.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_pointer <= tlb_regs_pkg::TOP_ENTRY;
		end else if (i_ce) begin
			if (i_reload) begin
				o_pointer <= tlb_regs_pkg::TOP_ENTRY;
			end else if (i_retire) begin
				if (o_pointer <= i_lower || o_pointer == tlb_regs_pkg::ZERO6) begin
					o_pointer <= tlb_regs_pkg::TOP_ENTRY;
				end else begin
					o_pointer <= o_pointer - tlb_regs_pkg::ONE6;
				end
			end
		end
	end
endmodule

// file: verilog/tlb_mgmt_timer_regs.sv
// Control register set for the translation buffer and the timebase alarm.
// Assumes the pipeline presents move-to/move-from and buffer operations as one-cycle strobes.
`timescale 1ns/10ps
// How it works
// - Probe miss sets flag, hit clears.
// - Low six bits index, top bit probe.
// - Replacement pointer read-only, selects random victim.
// - Pointer decrements after each instruction, wraps to top at boundary.
// - Pointer stays between boundary and 63.
// - Restart loads pointer with top.
// - Boundary write reloads pointer with top.
// - Reset clears pinned boundary.
// - Random writes never pick pinned entries.
// - Even and odd lo carry page pair.
// - Frame field holds address bits 47:12.
// - Global is AND of both bit zeros.
// - Invalid entry hit raises load/store fault.
// - Translation fault writes VA 31:13 into pair field.
// - Size mask excludes VA bits 24:13.
// - Only legal mask codes are defined.
// - Bit 29 selects 48 or 40 bits.
// - Wide enable writable only when supported.
// - Gate implements four user-access bits.
// - Fault address read-only, captures faulting VA.
// - Timebase counts once per two clocks.
// - Equal match raises timer interrupt.
// - Access needs kernel mode or usability.
module tlb_mgmt_timer_regs (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_kernel_mode,
	input wire logic i_sysco_usable,
	input wire logic i_mt_strobe,
	input wire logic i_mf_strobe,
	input wire logic [7:0] i_reg_sel,
	input wire logic [63:0] i_wdata,
	input wire logic i_retire,
	input wire logic i_wide_phys_support,
	input wire logic i_probe_op,
	input wire logic i_probe_hit,
	input wire logic [5:0] i_probe_slot,
	input wire logic i_read_entry_op,
	input wire logic [63:0] i_rd_even_lo,
	input wire logic [63:0] i_rd_odd_lo,
	input wire logic [31:0] i_rd_size_mask,
	input wire logic i_xlate_valid,
	input wire logic i_xlate_hit,
	input wire logic i_xlate_entry_valid,
	input wire logic i_xlate_store,
	input wire logic i_xlate_refill_miss,
	input wire logic i_addr_error,
	input wire logic [63:0] i_fault_va,
	output logic [63:0] o_rdata,
	output logic o_rvalid,
	output logic o_sysco_unusable,
	output logic o_load_xlate_fault,
	output logic o_store_xlate_fault,
	output logic [5:0] o_write_slot,
	output logic [5:0] o_random_slot,
	output logic o_entry_global,
	output logic [63:0] o_even_page_lo,
	output logic [63:0] o_odd_page_lo,
	output logic [31:0] o_page_size_selector,
	output logic o_wide_phys_enable,
	output logic [3:0] o_user_hwreg_gate,
	output logic o_alarm_hit_flag,
	output logic o_pending_irq7
);
	// ==========================================================
	// Storage
	// ==========================================================
	logic probe_fail_ff; // Probe outcome flag.
	logic [5:0] slot_ff; // Indexed slot.
	logic [63:0] even_lo_ff; // Even page mapping.
	logic [63:0] odd_lo_ff; // Odd page mapping.
	logic [63:0] table_base_ff; // Software-owned table base bits.
	logic [18:0] vpage_pair_ff; // Faulting page pair.
	logic [11:0] size_mask_ff; // Page size mask bits.
	logic wide_phys_ff; // Large address enable.
	logic [5:0] pinned_ff; // Pinned-entry boundary.
	logic [3:0] hwgate_ff; // User hardware-register gate.
	logic [63:0] fault_va_ff; // Last faulting address.
	logic [31:0] tally_ff; // Timebase counter.
	logic [31:0] alarm_ff; // Alarm match value.
	logic half_ff; // Divide-by-two phase.
	logic [5:0] repl_q; // Replacement pointer.
	logic allowed; // Access permitted.
	logic wr; // Qualified write.
	logic rd; // Qualified read.
	logic xlate_fault; // Invalid-entry fault this cycle.
	logic any_fault; // Any captured fault.
	logic [31:0] nxt_tally; // Counter next value.

	// Decode a selector match; callers qualify it with a permitted access.
	function automatic logic hit_sel(input logic [7:0] sel, input logic [7:0] want);
		hit_sel = (sel == want);
	endfunction

	assign allowed = i_kernel_mode | i_sysco_usable;
	assign wr = i_mt_strobe & allowed;
	assign rd = i_mf_strobe & allowed;
	assign xlate_fault = i_xlate_valid & i_xlate_hit & ~i_xlate_entry_valid;
	assign any_fault = xlate_fault | (i_xlate_valid & i_xlate_refill_miss) | i_addr_error;

	// ==========================================================
	// Replacement pointer
	// ==========================================================
	// The boundary write and its reload share one strobe and land on one edge.
	// pointer owned by hardware
	repl_pointer u_repl (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_retire(i_retire),
		.i_reload(wr && hit_sel(i_reg_sel, tlb_regs_pkg::SEL_PINNED)),
		.i_lower(pinned_ff),
		.o_pointer(repl_q)
	);

	// ==========================================================
	// Slot select and probe flag
	// ==========================================================
	// Probe results land here; software may also write the slot.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			probe_fail_ff <= 1'b0;
			slot_ff <= tlb_regs_pkg::ZERO6;
		end else if (i_ce) begin
			if (i_probe_op) begin
				probe_fail_ff <= ~i_probe_hit;
				if (i_probe_hit) begin
					slot_ff <= i_probe_slot;
				end
			end else if (wr && hit_sel(i_reg_sel, tlb_regs_pkg::SEL_SLOT)) begin
				slot_ff <= i_wdata[tlb_regs_pkg::IDX_W-1:0];
			end
		end
	end

	// ==========================================================
	// Page lo pair and size mask
	// ==========================================================
	// Loaded by software or by a buffer read.
	// Bits above the frame field are dropped, so they always read back as zero.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			even_lo_ff <= tlb_regs_pkg::ZERO64;
			odd_lo_ff <= tlb_regs_pkg::ZERO64;
			size_mask_ff <= 12'h000;
		end else if (i_ce) begin
			if (i_read_entry_op) begin
				even_lo_ff <= {22'h0, i_rd_even_lo[tlb_regs_pkg::LO_USED_W-1:0]};
				odd_lo_ff <= {22'h0, i_rd_odd_lo[tlb_regs_pkg::LO_USED_W-1:0]};
				size_mask_ff <= i_rd_size_mask[tlb_regs_pkg::MASK_MSB:tlb_regs_pkg::MASK_LSB];
			end else if (wr) begin
				if (hit_sel(i_reg_sel, tlb_regs_pkg::SEL_EVEN)) begin
					even_lo_ff <= {22'h0, i_wdata[tlb_regs_pkg::LO_USED_W-1:0]};
				end
				if (hit_sel(i_reg_sel, tlb_regs_pkg::SEL_ODD)) begin
					odd_lo_ff <= {22'h0, i_wdata[tlb_regs_pkg::LO_USED_W-1:0]};
				end
				if (hit_sel(i_reg_sel, tlb_regs_pkg::SEL_PSIZE)) begin
					size_mask_ff <= i_wdata[tlb_regs_pkg::MASK_MSB:tlb_regs_pkg::MASK_LSB];
				end
			end
		end
	end

	// ==========================================================
	// Page table pointer and fault address
	// ==========================================================
	// Hardware fills the pair field on translation faults and the fault address on any fault.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			table_base_ff <= tlb_regs_pkg::ZERO64;
			vpage_pair_ff <= 19'h00000;
			fault_va_ff <= tlb_regs_pkg::ZERO64;
		end else if (i_ce) begin
			if (wr && hit_sel(i_reg_sel, tlb_regs_pkg::SEL_PTP)) begin
				table_base_ff <= {i_wdata[63:tlb_regs_pkg::BASE_LSB], 23'h000000};
			end
			if (xlate_fault || (i_xlate_valid && i_xlate_refill_miss)) begin
				vpage_pair_ff <= i_fault_va[tlb_regs_pkg::VPAIR_MSB:tlb_regs_pkg::VPAIR_LSB];
			end
			if (any_fault) begin
				fault_va_ff <= i_fault_va;
			end
		end
	end

	// ==========================================================
	// Pinned boundary, grain and user gate
	// ==========================================================
	// Simple software registers.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			pinned_ff <= tlb_regs_pkg::ZERO6;
			wide_phys_ff <= 1'b0;
			hwgate_ff <= 4'h0;
		end else if (i_ce) begin
			if (wr && hit_sel(i_reg_sel, tlb_regs_pkg::SEL_PINNED)) begin
				pinned_ff <= i_wdata[tlb_regs_pkg::IDX_W-1:0];
			end
			if (!i_wide_phys_support) begin
				wide_phys_ff <= 1'b0;
			end else if (wr && hit_sel(i_reg_sel, tlb_regs_pkg::SEL_GRAIN)) begin
				wide_phys_ff <= i_wdata[tlb_regs_pkg::WIDE_PHYS_BIT];
			end
			if (wr && hit_sel(i_reg_sel, tlb_regs_pkg::SEL_HWGATE)) begin
				hwgate_ff <= i_wdata[tlb_regs_pkg::HWGATE_W-1:0];
			end
		end
	end

	// ==========================================================
	// Timebase and alarm
	// ==========================================================
	// count every second clock
	assign nxt_tally = half_ff ? tally_ff + tlb_regs_pkg::ONE32 : tally_ff;

	// Counter runs on every other enabled clock; software may load it.
	// A software load restarts the count but leaves the divide phase running.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			tally_ff <= tlb_regs_pkg::ZERO32;
			half_ff <= 1'b0;
			alarm_ff <= tlb_regs_pkg::ZERO32;
		end else if (i_ce) begin
			half_ff <= ~half_ff;
			if (wr && hit_sel(i_reg_sel, tlb_regs_pkg::SEL_TALLY)) begin
				tally_ff <= i_wdata[31:0];
			end else begin
				tally_ff <= nxt_tally;
			end
			if (wr && hit_sel(i_reg_sel, tlb_regs_pkg::SEL_ALARM)) begin
				alarm_ff <= i_wdata[31:0];
			end
		end
	end

	// Pending flag: a match in the write cycle wins over the clear.
	// Tally and alarm both leave reset at zero, so the flag rises on the first edge.
	// Software writes the alarm once to start from a clean flag.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_alarm_hit_flag <= 1'b0;
			o_pending_irq7 <= 1'b0;
		end else if (i_ce) begin
			if (tally_ff == alarm_ff) begin
				o_alarm_hit_flag <= 1'b1;
				o_pending_irq7 <= 1'b1;
			end else if (wr && hit_sel(i_reg_sel, tlb_regs_pkg::SEL_ALARM)) begin
				o_alarm_hit_flag <= 1'b0;
				o_pending_irq7 <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Buffer-facing outputs and faults
	// ==========================================================
	// Registered copies of the state the buffer array consumes.
	// Each copy lags its register by one edge, so the array sees a software
	// write two edges after the strobe.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_write_slot <= tlb_regs_pkg::ZERO6;
			o_random_slot <= tlb_regs_pkg::TOP_ENTRY;
			o_entry_global <= 1'b0;
			o_even_page_lo <= tlb_regs_pkg::ZERO64;
			o_odd_page_lo <= tlb_regs_pkg::ZERO64;
			o_page_size_selector <= tlb_regs_pkg::ZERO32;
			o_wide_phys_enable <= 1'b0;
			o_user_hwreg_gate <= 4'h0;
			o_load_xlate_fault <= 1'b0;
			o_store_xlate_fault <= 1'b0;
			o_sysco_unusable <= 1'b0;
		end else if (i_ce) begin
			o_write_slot <= slot_ff;
			o_random_slot <= (repl_q < pinned_ff) ? tlb_regs_pkg::TOP_ENTRY : repl_q;
			o_entry_global <= even_lo_ff[0] & odd_lo_ff[0];
			o_even_page_lo <= even_lo_ff;
			o_odd_page_lo <= odd_lo_ff;
			o_page_size_selector <= {7'h00, size_mask_ff, 13'h0000};
			o_wide_phys_enable <= wide_phys_ff;
			o_user_hwreg_gate <= hwgate_ff;
			o_load_xlate_fault <= xlate_fault & ~i_xlate_store;
			o_store_xlate_fault <= xlate_fault & i_xlate_store;
			o_sysco_unusable <= (i_mt_strobe | i_mf_strobe) & ~allowed;
		end
	end

	// ==========================================================
	// Read port
	// ==========================================================
	// Move-from returns one cycle after the strobe; unknown selectors read zero.
	// A refused move-from leaves o_rvalid low and raises the unusable pulse instead.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= tlb_regs_pkg::ZERO64;
			o_rvalid <= 1'b0;
		end else if (i_ce) begin
			o_rvalid <= rd;
			o_rdata <= tlb_regs_pkg::ZERO64;
			if (rd) begin
				unique case (i_reg_sel)
					tlb_regs_pkg::SEL_SLOT: o_rdata <= {32'h0, probe_fail_ff, 25'h0, slot_ff};
					tlb_regs_pkg::SEL_REPL: o_rdata <= {58'h0, repl_q};
					tlb_regs_pkg::SEL_EVEN: o_rdata <= even_lo_ff;
					tlb_regs_pkg::SEL_ODD: o_rdata <= odd_lo_ff;
					tlb_regs_pkg::SEL_PTP: o_rdata <= table_base_ff | {41'h0, vpage_pair_ff, 4'h0};
					tlb_regs_pkg::SEL_PSIZE: o_rdata <= {39'h0, size_mask_ff, 13'h0000};
					tlb_regs_pkg::SEL_GRAIN: o_rdata <= {34'h0, wide_phys_ff, 29'h00000000};
					tlb_regs_pkg::SEL_PINNED: o_rdata <= {58'h0, pinned_ff};
					tlb_regs_pkg::SEL_HWGATE: o_rdata <= {60'h0, hwgate_ff};
					tlb_regs_pkg::SEL_FAULT: o_rdata <= fault_va_ff;
					tlb_regs_pkg::SEL_TALLY: o_rdata <= {32'h0, tally_ff};
					tlb_regs_pkg::SEL_ALARM: o_rdata <= {32'h0, alarm_ff};
					default: o_rdata <= tlb_regs_pkg::ZERO64;
				endcase
			end
		end
	end
endmodule

// file: tb/tlb_regs_checker.sv
// ==========================================================
// Checker for the translation buffer control register set.
// Assumes one clock domain and the design's top module ports only.
`timescale 1ns/10ps
module tlb_regs_checker (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_kernel_mode,
	input wire logic i_sysco_usable,
	input wire logic i_mt_strobe,
	input wire logic i_mf_strobe,
	input wire logic [7:0] i_reg_sel,
	input wire logic [63:0] i_wdata,
	input wire logic i_retire,
	input wire logic i_wide_phys_support,
	input wire logic i_xlate_valid,
	input wire logic i_xlate_hit,
	input wire logic i_xlate_entry_valid,
	input wire logic i_xlate_store,
	input wire logic o_rvalid,
	input wire logic o_sysco_unusable,
	input wire logic o_load_xlate_fault,
	input wire logic o_store_xlate_fault,
	input wire logic [5:0] o_random_slot,
	input wire logic o_entry_global,
	input wire logic [63:0] o_even_page_lo,
	input wire logic [63:0] o_odd_page_lo,
	input wire logic o_wide_phys_enable,
	input wire logic o_alarm_hit_flag,
	input wire logic o_pending_irq7
);
	// Privileged access allowed this cycle.
	logic ok;
	assign ok = i_ce && (i_kernel_mode || i_sysco_usable);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// ==========================================================
	// Named steps.
	sequence grain_wr;
		ok && i_mt_strobe && i_reg_sel == tlb_regs_pkg::SEL_GRAIN;
	endsequence
	sequence retire_go;
		i_ce && i_retire && !i_mt_strobe;
	endsequence
	sequence bad_hit;
		i_ce && i_xlate_valid && i_xlate_hit && !i_xlate_entry_valid;
	endsequence
	// ==========================================================
	access_gate_a: assert property ((i_ce && (i_mt_strobe || i_mf_strobe)) |=>
		o_sysco_unusable == !($past(i_kernel_mode) || $past(i_sysco_usable)))
		else $error("access refusal wrong");
	read_answer_a: assert property (o_rvalid == $past(ok && i_mf_strobe))
		else $error("read answer wrong");
	ptr_reset_a: assert property (disable iff (1'b0)
		i_rst |=> o_random_slot == tlb_regs_pkg::TOP_ENTRY)
		else $error("pointer reset value wrong");
	ptr_step_a: assert property (retire_go |=> ##1
		(o_random_slot + 6'h01 == $past(o_random_slot) || o_random_slot == 6'h3f))
		else $error("pointer step wrong");
	global_flag_a: assert property (o_entry_global ==
		(o_even_page_lo[0] && o_odd_page_lo[0]))
		else $error("global flag wrong");
	frame_width_a: assert property (o_even_page_lo[63:42] == 22'h0)
		else $error("frame field too wide");
	wide_gate_a: assert property (grain_wr |=> ##1 o_wide_phys_enable ==
		($past(i_wdata[29], 2) && $past(i_wide_phys_support, 2)))
		else $error("wide enable wrong");
	xlate_fault_a: assert property (bad_hit |=>
		o_store_xlate_fault == $past(i_xlate_store) && o_load_xlate_fault != $past(i_xlate_store))
		else $error("invalid hit fault wrong");
	irq_mirror_a: assert property (o_pending_irq7 == o_alarm_hit_flag)
		else $error("pending bit differs from flag");
endmodule
bind tlb_mgmt_timer_regs tlb_regs_checker u_tlb_regs_checker (.*);

// file: tb/tlb_array_model.sv
// ==========================================================
// Model of the buffer array and probe logic beside the pipeline.
// Assumes the bench pulses write, read and probe requests at falling edges.
`timescale 1ns/10ps
module tlb_array_model (
	input wire logic i_clock,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_prb,
	input wire logic [63:0] i_key,
	input wire logic [5:0] i_slot,
	input wire logic [63:0] i_even,
	input wire logic [63:0] i_odd,
	input wire logic [31:0] i_mask,
	output logic o_probe_op,
	output logic o_probe_hit,
	output logic [5:0] o_probe_slot,
	output logic o_read_entry_op,
	output logic [63:0] o_rd_even_lo,
	output logic [63:0] o_rd_odd_lo,
	output logic [31:0] o_rd_size_mask
);
	logic [63:0] ev [64];
	logic [63:0] od [64];
	logic [31:0] mk [64];
	logic vl [64];
	initial begin
		{o_probe_op, o_probe_hit, o_probe_slot, o_read_entry_op} = '0;
		{o_rd_even_lo, o_rd_odd_lo, o_rd_size_mask} = '0;
		foreach (vl[i]) vl[i] = 1'b0;
	end
	// Idle result lines flip each cycle so stale values never look valid.
	always @(posedge i_clock) begin
		o_probe_op <= i_prb;
		o_read_entry_op <= i_rd;
		if (i_wr) begin
			ev[i_slot] <= i_even;
			od[i_slot] <= i_odd;
			mk[i_slot] <= i_mask;
			vl[i_slot] <= 1'b1;
		end
		o_rd_even_lo <= i_rd ? ev[i_slot] : ~o_rd_even_lo;
		o_rd_odd_lo <= i_rd ? od[i_slot] : ~o_rd_odd_lo;
		o_rd_size_mask <= i_rd ? mk[i_slot] : ~o_rd_size_mask;
		o_probe_hit <= ~o_probe_hit;
		o_probe_slot <= ~o_probe_slot;
		if (i_prb) begin
			o_probe_hit <= 1'b0;
			for (int i = 0; i < 64; i++) begin
				if (vl[i] && ev[i] === i_key) begin
					o_probe_hit <= 1'b1;
					o_probe_slot <= 6'(i);
				end
			end
		end
	end
endmodule

// file: tb/tb_tlb_mgmt_timer_regs.sv
// ==========================================================
// Self-checking bench for the translation buffer control register set.
// Assumes the array model in tlb_array_model and a 50 MHz clock.
`timescale 1ns/10ps
`define CK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_tlb_mgmt_timer_regs;
	logic i_clock, i_rst, i_ce, i_kernel_mode, i_sysco_usable, i_mt_strobe, i_mf_strobe;
	logic i_retire, i_wide_phys_support, i_probe_op, i_probe_hit, i_read_entry_op;
	logic i_xlate_valid, i_xlate_hit, i_xlate_entry_valid, i_xlate_store;
	logic i_xlate_refill_miss, i_addr_error, o_rvalid, o_sysco_unusable;
	logic o_load_xlate_fault, o_store_xlate_fault, o_entry_global, o_wide_phys_enable;
	logic o_alarm_hit_flag, o_pending_irq7, m_wr, m_rd, m_prb;
	logic [7:0] i_reg_sel;
	logic [63:0] i_wdata, i_rd_even_lo, i_rd_odd_lo, i_fault_va, o_rdata;
	logic [63:0] o_even_page_lo, o_odd_page_lo, m_key, rd, va;
	logic [5:0] i_probe_slot, o_write_slot, o_random_slot;
	logic [31:0] i_rd_size_mask, o_page_size_selector;
	logic [3:0] o_user_hwreg_gate;
	int n_mismatch, num_checks, n;
	tlb_mgmt_timer_regs u_tlb_mgmt_timer_regs (.*);
	tlb_array_model u_tlb_array_model (.i_clock(i_clock), .i_wr(m_wr), .i_rd(m_rd),
		.i_prb(m_prb), .i_key(m_key), .i_slot(o_write_slot), .i_even(o_even_page_lo),
		.i_odd(o_odd_page_lo), .i_mask(o_page_size_selector), .o_probe_op(i_probe_op),
		.o_probe_hit(i_probe_hit), .o_probe_slot(i_probe_slot),
		.o_read_entry_op(i_read_entry_op), .o_rd_even_lo(i_rd_even_lo),
		.o_rd_odd_lo(i_rd_odd_lo), .o_rd_size_mask(i_rd_size_mask));
	// Clock at 20 ns.
	always #10 i_clock = ~i_clock;
	task automatic tick(int k);
		repeat (k) @(negedge i_clock);
	endtask
	// Write a register; the strobe stands over one rising edge.
	task automatic mt(logic [7:0] s, logic [63:0] d);
		i_reg_sel = s;
		i_wdata = d;
		i_mt_strobe = 1'b1;
		tick(1);
		i_mt_strobe = 1'b0;
		i_wdata = ~d;
		tick(2);
	endtask
	// Read a register; the answer stands one cycle after the take.
	task automatic mf(logic [7:0] s);
		i_reg_sel = s;
		i_mf_strobe = 1'b1;
		tick(1);
		i_mf_strobe = 1'b0;
		`CK("rvalid", 1'b1, o_rvalid) // answer given.
		rd = o_rdata;
		tick(1);
	endtask
	// Pulse one model request for one cycle, then let it reach the design.
	task automatic pulse(ref logic r);
		r = 1'b1;
		tick(1);
		r = 1'b0;
		tick(2);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Pointer walk, boundary reload and wrap.
	task automatic t_ptr();
		mf(tlb_regs_pkg::SEL_PINNED);
		`CK("pinned", 64'h0, rd) // reset clear.
		mf(tlb_regs_pkg::SEL_REPL);
		`CK("repl", 64'h3f, rd) // restart top.
		mt(tlb_regs_pkg::SEL_PINNED, 64'h5);
		mt(tlb_regs_pkg::SEL_REPL, 64'h0);
		mf(tlb_regs_pkg::SEL_REPL);
		`CK("reload", 64'h3f, rd) // reload, read-only.
		i_retire = 1'b1;
		for (int k = 0; k < 58; k++) begin
			tick(1);
			`CK("floor", 1'b1, o_random_slot >= 6'h05) // pinned kept.
		end
		i_retire = 1'b0;
		mf(tlb_regs_pkg::SEL_REPL);
		`CK("walk", 64'h5, rd) // one per instruction.
		pulse(i_retire);
		mf(tlb_regs_pkg::SEL_REPL);
		`CK("wrap", 64'h3f, rd) // back to top.
		mt(tlb_regs_pkg::SEL_PINNED, 64'h0);
		$display("test ptr done");
	endtask
	// Slot register, lo registers, probe and entry read.
	task automatic t_slot();
		mt(tlb_regs_pkg::SEL_SLOT, 64'h2a);
		`CK("wslot", 6'h2a, o_write_slot) // index used.
		mt(tlb_regs_pkg::SEL_EVEN, '1);
		mf(tlb_regs_pkg::SEL_EVEN);
		`CK("frame", 64'h3ffffffffff, rd) // kept bits.
		mt(tlb_regs_pkg::SEL_ODD, 64'h1);
		`CK("glob1", 1'b1, o_entry_global) // both set.
		mt(tlb_regs_pkg::SEL_ODD, 64'h2);
		`CK("glob0", 1'b0, o_entry_global) // one clear.
		pulse(m_wr);
		m_key = 64'h3ffffffffff;
		pulse(m_prb);
		mf(tlb_regs_pkg::SEL_SLOT);
		`CK("hit", 64'h2a, rd) // success clears.
		m_key = 64'h0;
		pulse(m_prb);
		mf(tlb_regs_pkg::SEL_SLOT);
		`CK("miss", 64'h8000002a, rd) // failure sets.
		mt(tlb_regs_pkg::SEL_EVEN, 64'h0);
		pulse(m_rd);
		mf(tlb_regs_pkg::SEL_EVEN);
		`CK("rdeven", 64'h3ffffffffff, rd) // even page.
		mf(tlb_regs_pkg::SEL_ODD);
		`CK("rdodd", 64'h2, rd) // odd page.
		$display("test slot done");
	endtask
	// Mask codes, page granularity, user gate and privilege.
	task automatic t_cfg();
		logic [63:0] v;
		for (int k = 0; k < 7; k++) begin
			v = ((64'h1 << (2 * k)) - 64'h1) << 13;
			mt(tlb_regs_pkg::SEL_PSIZE, v);
			mf(tlb_regs_pkg::SEL_PSIZE);
			`CK("psize", v, rd) // legal codes.
			`CK("mask", v[31:0], o_page_size_selector) // mask out.
		end
		i_wide_phys_support = 1'b0;
		mt(tlb_regs_pkg::SEL_GRAIN, '1);
		mf(tlb_regs_pkg::SEL_GRAIN);
		`CK("grain0", 64'h0, rd) // unsupported.
		i_wide_phys_support = 1'b1;
		mt(tlb_regs_pkg::SEL_GRAIN, '1);
		mf(tlb_regs_pkg::SEL_GRAIN);
		`CK("grain1", 64'h20000000, rd) // only bit set.
		mt(tlb_regs_pkg::SEL_HWGATE, '1);
		`CK("ugate", 4'hf, o_user_hwreg_gate) // gate output.
		mf(tlb_regs_pkg::SEL_HWGATE);
		`CK("gate", 64'hf, rd) // four bits.
		i_kernel_mode = 1'b0;
		mt(tlb_regs_pkg::SEL_HWGATE, 64'h0);
		`CK("refuse", 4'hf, o_user_hwreg_gate) // write refused.
		i_sysco_usable = 1'b1;
		mt(tlb_regs_pkg::SEL_HWGATE, 64'h5);
		i_kernel_mode = 1'b1;
		mf(tlb_regs_pkg::SEL_HWGATE);
		`CK("usable", 64'h5, rd) // usability path.
		$display("test cfg done");
	endtask
	// Fault capture into the page table pointer and fault address.
	task automatic t_fault();
		va = 64'h123456789abce000;
		mt(tlb_regs_pkg::SEL_PTP, '1);
		i_fault_va = va;
		{i_xlate_valid, i_xlate_hit, i_xlate_store} = 3'b111;
		tick(1);
		{i_xlate_valid, i_xlate_hit, i_xlate_store} = 3'b000;
		`CK("stfault", 1'b1, o_store_xlate_fault) // store kind.
		tick(1);
		mf(tlb_regs_pkg::SEL_PTP);
		`CK("ptp", {41'h1ffffffffff, va[31:13], 4'h0}, rd) // pair field.
		i_fault_va = ~va;
		pulse(i_addr_error);
		mt(tlb_regs_pkg::SEL_FAULT, 64'h0);
		mf(tlb_regs_pkg::SEL_FAULT);
		`CK("fault", ~va, rd) // captured, read-only.
		i_xlate_refill_miss = 1'b1;
		pulse(i_xlate_valid);
		i_xlate_refill_miss = 1'b0;
		mf(tlb_regs_pkg::SEL_PTP);
		`CK("refill", {41'h1ffffffffff, ~va[31:13], 4'h0}, rd) // refill miss.
		$display("test fault done");
	endtask
	// Timebase rate, alarm clear and alarm match.
	task automatic t_timer();
		logic [63:0] a;
		mt(tlb_regs_pkg::SEL_ALARM, 64'hffff0000);
		`CK("clear", 1'b0, o_alarm_hit_flag) // write clears.
		mf(tlb_regs_pkg::SEL_TALLY);
		a = rd;
		tick(18);
		mf(tlb_regs_pkg::SEL_TALLY);
		`CK("rate", a + 64'h0a, rd) // every two cycles.
		mt(tlb_regs_pkg::SEL_TALLY, 64'h100);
		mt(tlb_regs_pkg::SEL_ALARM, 64'h108);
		`CK("early", 1'b0, o_alarm_hit_flag) // not yet equal.
		for (n = 0; n < 40 && o_alarm_hit_flag !== 1'b1; n++) tick(1);
		`CK("match", 1'b1, o_alarm_hit_flag) // equal raises.
		`CK("irq7", 1'b1, o_pending_irq7) // pending bit.
		if (n == 40) end_of_test();
		$display("test timer done");
	endtask
	initial begin
		{i_clock, i_mt_strobe, i_mf_strobe, i_retire, i_addr_error, m_wr, m_rd, m_prb} = '0;
		{i_xlate_valid, i_xlate_hit, i_xlate_entry_valid, i_xlate_store} = '0;
		{i_sysco_usable, i_wide_phys_support, i_xlate_refill_miss} = '0;
		{i_rst, i_ce, i_kernel_mode} = 3'b111;
		{i_reg_sel, i_wdata, i_fault_va, m_key} = '0;
		n_mismatch = 0;
		num_checks = 0;
		repeat (10) @(posedge i_clock);
		tick(1);
		i_rst = 1'b0;
		t_ptr();
		t_slot();
		t_cfg();
		t_fault();
		t_timer();
		end_of_test();
	end
endmodule
